/* oals_device.sv */
`timescale 1ns/1ps
module oals_device
	import oals_pkg::*;
(
	input  wire logic                   sys_clk,   // System clock
	input  wire logic                   rst_n,     // Synchronous reset, low
	oals_link_if.device                 link,      // Link to host
	input  wire logic [RESULT_BITS-1:0] analog_result [CHANNEL_COUNT], // Channel results to convert
	output logic                        busy       // Readout armed by the first strobe fall, held until reset
);
	// Synchronised pins and their history
	logic [3:0] pin_s;
	logic       strobe_s, sck_s, ddr_s, diff_s;
	logic       strobe_q, sck_q;
	logic       strobe_rise;  // Sampling begins
	logic       strobe_fall;  // Readout begins
	// Readout state
	logic [RESULT_BITS-1:0] held_q [CHANNEL_COUNT];
	logic [CNT_W-1:0]       bit_q;
	logic                   active_q;
	logic [2:0]             word_idx; // Result slot in the rotation
	logic [3:0]             bit_idx;  // Bit of the result, MSB first
	// Lane registers
	logic [7:0]             cmos_q;
	logic [3:0]             diff_q;
	logic                   echo_q;
	logic                   shift_ev;

	// ------------------------------------------------------------
	// Pin sampling
	// ------------------------------------------------------------
	oals_sync #(.WIDTH(4)) u_sync (
		.sys_clk  (sys_clk),
		.rst_n    (rst_n),
		.async_in ({link.conversion_strobe, link.shift_clock, link.edge_rate_select, link.diff_mode}),
		.sync_out (pin_s)
	);
	assign {strobe_s, sck_s, ddr_s, diff_s} = pin_s;

	// Edge history
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			strobe_q <= 1'b0;
			sck_q    <= 1'b0;
		end
		else
		begin
			strobe_q <= strobe_s;
			sck_q    <= sck_s;
		end
	end

	// ------------------------------------------------------------
	// Shift events
	// ------------------------------------------------------------
	// Falling edge in single rate, any edge in dual rate
	// Ignored until a strobe fall has armed the readout
	assign shift_ev = active_q && (ddr_s ? (sck_s != sck_q) : (sck_q && !sck_s));

	// ------------------------------------------------------------
	// Sample and readout control
	// ------------------------------------------------------------
	// Strobe edges on the synchronised pin
	assign strobe_rise = strobe_s && !strobe_q;
	assign strobe_fall = strobe_q && !strobe_s;

	// Results frozen at strobe rise; cleared so lanes stay low until the first strobe rise
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < CHANNEL_COUNT; i++)
				held_q[i] <= '0;
		end
		else if (strobe_rise)
		begin
			held_q <= analog_result;
		end
	end

	// Readout armed by the first strobe fall, kept until reset
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			active_q <= 1'b0;
		end
		else if (strobe_fall)
		begin
			active_q <= 1'b1;
		end
	end

	// Stream position; its wrap keeps the rotation going forever
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			bit_q <= '0;
		end
		else if (strobe_fall)
		begin
			bit_q <= '0;
		end
		else if (shift_ev)
		begin
			bit_q <= bit_q + 8'h01;
		end
	end

	// ------------------------------------------------------------
	// Lane data: lane k starts with channel k, pair k with channel 2k, rotates circularly
	// ------------------------------------------------------------
	// Word and bit of the stream, shared by every lane
	assign word_idx = bit_q[6:4];
	assign bit_idx  = 4'hf - bit_q[3:0];

	genvar k;
	generate
		// Single-ended lanes, one channel apart
		for (k = 0; k < CMOS_LANES; k++)
		begin : g_cmos
			logic [2:0] ch; // Channel on this lane now
			assign ch = 3'(k) + word_idx;
			// Registered so all lanes move together
			always_ff @(posedge sys_clk)
			begin
				if (!rst_n)
				begin
					cmos_q[k] <= 1'b0;
				end
				else
				begin
					cmos_q[k] <= held_q[ch][bit_idx];
				end
			end
		end
		// Differential pairs, two channels apart
		for (k = 0; k < DIFF_PAIRS; k++)
		begin : g_diff
			logic [2:0] ch; // Channel on this pair now
			assign ch = 3'(2 * k) + word_idx;
			// Registered so all pairs move together
			always_ff @(posedge sys_clk)
			begin
				if (!rst_n)
				begin
					diff_q[k] <= 1'b0;
				end
				else
				begin
					diff_q[k] <= held_q[ch][bit_idx];
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// Echoed clock
	// ------------------------------------------------------------
	// One register behind the synchronised shift clock, one cycle ahead of the lanes
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			echo_q <= 1'b0;
		end
		else
		begin
			echo_q <= sck_s;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// Lane select by I/O standard; the unused set is held low
	// so a receiver wired for the other standard sees quiet lines
	assign link.cmos_lane          = diff_s ? 8'h00 : cmos_q;
	assign link.diff_pair          = diff_s ? diff_q : 4'h0;
	assign link.echoed_shift_clock = echo_q;
	assign busy                    = active_q;
endmodule : oals_device

/* oals_pkg.sv */
package oals_pkg;
	// ------------------------------------------------------------
	// Geometry
	// ------------------------------------------------------------
	localparam int CHANNEL_COUNT   = 8;
	localparam int RESULT_BITS     = 16;
	localparam int CMOS_LANES      = 8;
	localparam int DIFF_PAIRS      = 4;
	localparam int READOUT_BITS    = CHANNEL_COUNT * RESULT_BITS; // 128 bits per lane max
	localparam int CNT_W           = 8;
	// ------------------------------------------------------------
	// Host timing
	// ------------------------------------------------------------
	localparam int SYS_CLK_PERIOD_NS = 5;
	localparam int STROBE_HIGH_NS    = 30;
	localparam int STROBE_HIGH_CYC   = (STROBE_HIGH_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
	localparam int CONV_TIME_NS      = 100;
	localparam int CONV_TIME_CYC     = (CONV_TIME_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
	localparam int SHIFT_HALF_CYC    = 16; // 160 ns shift clock period
	localparam logic [7:0] RESET_SHIFT_LIMIT = 8'h80;
endpackage : oals_pkg

/* oals_link_if.sv */
`timescale 1ns/1ps
interface oals_link_if;
	logic       conversion_strobe;  // Host strobe, high samples, fall converts
	logic       shift_clock;        // Host shift clock
	logic       edge_rate_select;   // 0 single-rate, 1 dual-edge
	logic       diff_mode;          // 0 single-ended lanes, 1 differential pairs
	logic [7:0] cmos_lane;          // Single-ended lanes 1..8
	logic [3:0] diff_pair;          // Differential pairs a..d
	logic       echoed_shift_clock; // Delayed shift clock copy
	modport device (
		input  conversion_strobe, shift_clock, edge_rate_select, diff_mode,
		output cmos_lane, diff_pair, echoed_shift_clock
	);
	modport host (
		output conversion_strobe, shift_clock, edge_rate_select, diff_mode,
		input  cmos_lane, diff_pair, echoed_shift_clock
	);
endinterface : oals_link_if

/* oals_sync.sv */
`timescale 1ns/1ps
module oals_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             sys_clk, // System clock
	input  wire logic             rst_n,   // Synchronous reset, low
	input  wire logic [WIDTH-1:0] async_in, // Pin inputs
	output logic      [WIDTH-1:0] sync_out  // Synchronised copy
);
	logic [WIDTH-1:0] meta_q;
	// ------------------------------------------------------------
	// Two flop synchroniser
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			meta_q   <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule : oals_sync

/* oals_host.sv */
`timescale 1ns/1ps
module oals_host
	import oals_pkg::*;
(
	input  wire logic                   sys_clk,   // System clock
	input  wire logic                   rst_n,     // Synchronous reset, low
	oals_link_if.host                   link,      // Link to device
	input  wire logic                   start,     // Begin one conversion frame
	input  wire logic                   ddr_mode,  // Dual-edge select
	input  wire logic                   diff_sel,  // Differential select
	input  wire logic [3:0]             lanes,     // Lanes used: 1,2,4,8 (diff 1,2,4)
	output logic [RESULT_BITS-1:0]      result [CHANNEL_COUNT], // Captured results
	output logic                        done       // Frame complete pulse
);
	typedef enum logic [1:0] {S_IDLE = 2'b00, S_STROBE = 2'b01, S_CONV = 2'b10, S_SHIFT = 2'b11} oals_state_type;
	oals_state_type st_q;
	logic [7:0] cnt_q, edges_q, need;
	logic       sck_q, strobe_q;
	logic [7:0] din_s;
	logic [7:0] lane_v;
	logic [3:0] per;    // Results read per lane
	logic [7:0] idx;    // Bit index along a lane
	logic       sample; // Capture point
	logic [RESULT_BITS-1:0] sh_q [CHANNEL_COUNT];

	// Edges needed: 128/lanes in dual rate, twice that in single rate with two edges per cycle
	always_comb
	begin
		unique case (lanes)
			4'h8:    need = 8'h10;
			4'h4:    need = 8'h20;
			4'h2:    need = 8'h40;
			default: need = 8'h80;
		endcase
	end

	oals_sync #(.WIDTH(8)) u_sync (
		.sys_clk  (sys_clk),
		.rst_n    (rst_n),
		.async_in (diff_sel ? {4'h0, link.diff_pair} : link.cmos_lane),
		.sync_out (din_s)
	);

	// Lanes in use sample from lanes 1,3,5,7 or 1,5 or 1 (pairs a,c / a)
	always_comb
	begin
		lane_v = din_s;
	end

	// ------------------------------------------------------------
	// Frame sequencing: strobe, wait conversion, shift
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			st_q     <= S_IDLE;
			cnt_q    <= '0;
			edges_q  <= '0;
			sck_q    <= 1'b0;
			strobe_q <= 1'b0;
			done     <= 1'b0;
		end
		else
		begin
			done <= 1'b0;
			unique case (st_q)
				S_IDLE:
					if (start)
					begin
						st_q     <= S_STROBE;
						strobe_q <= 1'b1;
						cnt_q    <= '0;
					end
				S_STROBE:
					if (cnt_q == 8'(STROBE_HIGH_CYC))
					begin
						st_q     <= S_CONV;
						strobe_q <= 1'b0;
						cnt_q    <= '0;
					end
					else
						cnt_q <= cnt_q + 8'h01;
				S_CONV:
					if (cnt_q == 8'(CONV_TIME_CYC))
					begin
						st_q    <= S_SHIFT;
						cnt_q   <= '0;
						edges_q <= '0;
					end
					else
						cnt_q <= cnt_q + 8'h01;
				S_SHIFT:
					if (cnt_q == 8'(SHIFT_HALF_CYC - 1))
					begin
						cnt_q <= '0;
						sck_q <= ~sck_q;
						if (edges_q == (ddr_mode ? need - 8'h01 : 8'((need << 1) - 8'h01)))
						begin
							st_q <= S_IDLE;
							done <= 1'b1;
						end
						edges_q <= edges_q + 8'h01;
					end
					else
						cnt_q <= cnt_q + 8'h01;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Capture: sample lanes mid half-period, before each shifting edge
	// ------------------------------------------------------------
	// Single rate samples while the clock is high, before the fall shifts
	assign per    = need[7:4];
	assign sample = st_q == S_SHIFT && cnt_q == 8'(SHIFT_HALF_CYC / 2) && (ddr_mode || sck_q);
	assign idx    = ddr_mode ? edges_q : (edges_q >> 1);
	genvar c;
	generate
		for (c = 0; c < CHANNEL_COUNT; c++)
		begin : g_cap
			// Channel c is word (c mod per) of the lane starting at c - slot
			logic [2:0] ln;
			logic [2:0] slot;
			logic [2:0] base;
			logic       cap;
			assign slot = 3'(c) & 3'(per - 4'h1);
			assign base = 3'(c) - slot;
			assign ln   = diff_sel ? (base >> 1) : base;
			assign cap  = sample && idx[6:4] == slot;
			always_ff @(posedge sys_clk)
			begin
				if (!rst_n)
					sh_q[c] <= '0;
				else if (cap)
					sh_q[c] <= {sh_q[c][RESULT_BITS-2:0], lane_v[ln]};
			end
			always_ff @(posedge sys_clk)
			begin
				if (!rst_n)
					result[c] <= '0;
				else if (done)
					result[c] <= sh_q[c];
			end
		end
	endgenerate

	assign link.conversion_strobe = strobe_q;
	assign link.shift_clock       = sck_q;
	assign link.edge_rate_select  = ddr_mode;
	assign link.diff_mode         = diff_sel;
endmodule : oals_host

/* oals_link_asserts.sv */
`timescale 1ns/1ps
module oals_link_asserts (
	input wire logic       sys_clk,            // System clock
	input wire logic       rst_n,              // Reset, low
	input wire logic       conversion_strobe,  // Strobe
	input wire logic       shift_clock,        // Shift clock
	input wire logic       edge_rate_select,   // Dual-edge select
	input wire logic       diff_mode,          // Pair select
	input wire logic [7:0] cmos_lane,          // Lanes
	input wire logic [3:0] diff_pair,          // Pairs
	input wire logic       echoed_shift_clock  // Echo clock
);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	logic [4:0] since_q;   // Cycles since an edge that may move a lane
	logic       latched_q; // Strobe rise seen
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// Age of the last shifting, strobe or mode edge
	always_ff @(posedge sys_clk)
		if (!rst_n || $changed(conversion_strobe) || $fell(shift_clock) || $changed(diff_mode)
			|| $changed(edge_rate_select) || (edge_rate_select && $rose(shift_clock)))
			since_q <= 5'h00;
		else if (since_q != 5'h1f)
			since_q <= since_q + 5'h01;
	// Results latched once a strobe rose
	always_ff @(posedge sys_clk)
		if (!rst_n)
			latched_q <= 1'b0;
		else if ($rose(conversion_strobe))
			latched_q <= 1'b1;
	// ----------------------------------------
	// Checks
	// ----------------------------------------
	chk_echo_rise: assert property ($rose(shift_clock) |-> ##[1:5] echoed_shift_clock)
		else $error("echo clock missed a rise");
	chk_echo_fall: assert property ($fell(shift_clock) |-> ##[1:5] !echoed_shift_clock)
		else $error("echo clock missed a fall");
	chk_echo_idle: assert property ($stable(shift_clock) [*6] |-> echoed_shift_clock == shift_clock)
		else $error("echo clock differs from a still shift clock");
	chk_lane_edge: assert property ($changed(cmos_lane) |-> since_q < 5'h08)
		else $error("lane moved without a shifting edge");
	chk_pair_edge: assert property ($changed(diff_pair) |-> since_q < 5'h08)
		else $error("pair moved without a shifting edge");
	chk_sdr_lane_rise: assert property (!edge_rate_select && $rose(shift_clock) |-> ##1 $stable(cmos_lane) [*6])
		else $error("lane moved on a rising edge in single rate");
	chk_sdr_pair_rise: assert property (!edge_rate_select && $rose(shift_clock) |-> ##1 $stable(diff_pair) [*6])
		else $error("pair moved on a rising edge in single rate");
	chk_idle_lanes: assert property (!latched_q |-> cmos_lane == 8'h00 && diff_pair == 4'h0)
		else $error("lanes active before any strobe");
	cov_ddr: cover property ($fell(conversion_strobe) && edge_rate_select);
	cov_pairs: cover property ($fell(conversion_strobe) && diff_mode);
	cov_sdr_cmos: cover property ($fell(conversion_strobe) && !edge_rate_select && !diff_mode);
endmodule : oals_link_asserts

/* octal_adc_lane_sequencer_bench.sv */
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_tests++; if ((ex) !== (got)) begin bad_count++; $display("mismatch %s exp %h got %h", nm, ex, got); end end
module octal_adc_lane_sequencer_bench
	import oals_pkg::*;
;
	logic                   sys_clk = 1'b0;      // System clock
	logic                   rst_n   = 1'b0;      // Reset, low
	logic                   start   = 1'b0;      // Frame request
	logic                   ddr     = 1'b0;      // Dual-edge select
	logic                   dsel    = 1'b0;      // Pair select
	logic [3:0]             nl      = 4'h1;      // Lanes used
	logic                   cap     = 1'b0;      // Wire capture on
	logic [RESULT_BITS-1:0] ain [CHANNEL_COUNT]; // Channel inputs
	logic [RESULT_BITS-1:0] res [CHANNEL_COUNT]; // Host results
	logic [RESULT_BITS-1:0] ww [8][8];           // Words seen per lane
	logic                   done;                // Frame done
	logic                   busy;                // Readout seen
	int                     ne;                  // Sampled edges
	int                     bad_count;           // Mismatches
	int                     n_tests;             // Comparisons
	int                     exp_q [$];           // Model channel values
	oals_link_if link ();
	oals_device i_oals_device (.sys_clk(sys_clk), .rst_n(rst_n), .link(link.device), .analog_result(ain), .busy(busy));
	oals_host i_oals_host (.sys_clk(sys_clk), .rst_n(rst_n), .link(link.host), .start(start), .ddr_mode(ddr),
		.diff_sel(dsel), .lanes(nl), .result(res), .done(done));
	oals_link_asserts i_oals_link_asserts (.sys_clk(sys_clk), .rst_n(rst_n),
		.conversion_strobe(link.conversion_strobe), .shift_clock(link.shift_clock),
		.edge_rate_select(link.edge_rate_select), .diff_mode(link.diff_mode), .cmos_lane(link.cmos_lane),
		.diff_pair(link.diff_pair), .echoed_shift_clock(link.echoed_shift_clock));
	// Clock
	always #2.5 sys_clk = ~sys_clk;
	// Sample every lane at each edge in dual rate, each rise in single rate, before the shift
	always @(link.shift_clock)
		if (cap && (ddr || link.shift_clock) && ne < 128)
		begin
			for (int k = 0; k < 8; k++)
				ww[k][ne/16] = {ww[k][ne/16][14:0], dsel ? link.diff_pair[k%4] : link.cmos_lane[k]};
			ne++;
		end
	// Verdict and end of run
	task automatic give_verdict();
		if (bad_count == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : give_verdict
	// One conversion frame, checked on the wire and at the host
	task automatic frame(input logic d, input logic s, input logic [3:0] n);
		int t;
		@(posedge sys_clk);
		exp_q.delete();
		for (int c = 0; c < 8; c++)
		begin
			exp_q.push_back($urandom_range(16'hffff));
			ain[c] <= RESULT_BITS'(exp_q[c]);
		end
		ddr <= d;
		dsel <= s;
		nl <= n;
		start <= 1'b1;
		ne = 0;
		cap = 1'b1;
		@(posedge sys_clk);
		start <= 1'b0;
		t = 0;
		while (done !== 1'b1 && t < 9000)
		begin
			@(posedge sys_clk);
			t++;
		end
		if (t == 9000)
		begin
			bad_count++;
			give_verdict();
		end
		#1;
		cap = 1'b0;
		`CHK("edges", 128 / n, ne)
		for (int c = 0; c < 8; c++)
			`CHK("result", RESULT_BITS'(exp_q[c]), res[c])
		for (int k = 0; k < (s ? 4 : 8); k++)
			for (int w = 0; w < ne / 16; w++)
				`CHK("lane", RESULT_BITS'(exp_q[(k * (s ? 2 : 1) + w) % 8]), ww[k][w])
	endtask : frame
	// Main sequence over every mode and lane count
	initial
	begin
		foreach (ain[i])
			ain[i] = '0;
		void'($urandom(32'h99166e70));
		repeat (5) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		`CHK("busy", 1'b0, busy)
		for (int s = 0; s < 2; s++)
			for (int d = 0; d < 2; d++)
				for (int n = 1; n <= (s ? 4 : 8); n = n * 2)
					frame(d[0], s[0], 4'(n));
		`CHK("busy", 1'b1, busy)
		give_verdict();
	end
endmodule : octal_adc_lane_sequencer_bench
